// *** hw/rflcr_pkg.sv ***
package rflcr_pkg;
  // =====================================================================
  // register map, 7-bit byte addresses, word at the even address
  localparam logic [6:0] ADDR_PAGE    = 7'h00;
  localparam logic [6:0] ADDR_GW_CP   = 7'h08;
  localparam logic [6:0] ADDR_GW_TEST = 7'h10;
  localparam logic [6:0] ADDR_S_CP    = 7'h58;
  localparam logic [6:0] ADDR_S_OPT   = 7'h5c;
  localparam logic [6:0] ADDR_S_INT   = 7'h5e;
  localparam logic [6:0] ADDR_S_BASE  = 7'h60;
  // =====================================================================
  // reset values
  localparam logic [15:0] RST_CP   = 16'h0008;
  localparam logic [15:0] RST_TEST = 16'h0000;
  localparam logic [15:0] RST_OPT  = 16'h0000;
  localparam logic [15:0] RST_INT  = 16'h0fa0;
  localparam logic [15:0] RST_BASE = 16'h0001;
  localparam logic [2:0]  RST_PAGE = 3'h0;
  // =====================================================================
  // field layout; unused bits read as zero through these masks
  localparam int          CH_LSB    = 8;
  localparam int          CH_W      = 6;
  localparam int          PWR_W     = 5;
  localparam int          BIT_CW    = 11;
  localparam int          BIT_HOPC  = 10;
  localparam int          BIT_HOPEN = 6;
  localparam int          BIT_ALARM = 1;
  localparam logic [15:0] MASK_CP   = 16'h3f1f;
  localparam logic [15:0] MASK_OPT  = 16'h0c42;
  localparam logic [15:0] MASK_TEST = 16'h0c00;
  localparam logic [15:0] MASK_BASE = 16'h0003;
  localparam logic [2:0]  PAGE_MAX  = 3'h6;
  localparam int          NUM_SENS  = 6;
  localparam logic [4:0]  FRAME_BITS = 5'h10;
  // =====================================================================
  // time bases of one interval count, clock 25 MHz
  localparam longint CLK_HZ      = 25000000;
  localparam longint BASE0_PS    = 30520000;
  localparam longint BASE1_US    = 488;
  localparam longint BASE2_DIV   = 128;
  localparam longint BASE3_S     = 1;
  localparam longint BASE0_CYC   = BASE0_PS * CLK_HZ / 64'd1000000000000;
  localparam longint BASE1_CYC   = BASE1_US * CLK_HZ / 64'd1000000;
  localparam longint BASE2_CYC   = CLK_HZ / BASE2_DIV;
  localparam longint BASE3_CYC   = BASE3_S * CLK_HZ;
  localparam int     BASE_CNT_W  = 25;
endpackage

// *** hw/rflcr_wake_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rflcr_wake_if;
  logic [15:0] interval;
  logic [1:0]  scale;
  logic        wake;
  modport ctrl  (output interval, output scale, input wake);
  modport timer (input interval, input scale, output wake);
endinterface
`default_nettype wire

// *** hw/rflcr_wake_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module rflcr_wake_timer #(
  parameter logic [24:0] BASE0 = 25'd763,
  parameter logic [24:0] BASE1 = 25'd12200,
  parameter logic [24:0] BASE2 = 25'd195312,
  parameter logic [24:0] BASE3 = 25'd25000000
) (
  input  wire logic    clk_in,
  input  wire logic    reset_in,
  rflcr_wake_if.timer  wk
);
  logic [24:0] base_cnt;
  logic [24:0] base_len;
  logic [15:0] int_cnt;
  logic [15:0] int_len;
  logic        tick;

  // =====================================================================
  // time base select and interval length
  always_comb
  begin
    case (wk.scale)
      2'h0:    base_len = BASE0;
      2'h1:    base_len = BASE1;
      2'h2:    base_len = BASE2;
      default: base_len = BASE3;
    endcase
  end
  // a zero interval would never expire; it is treated as one count
  assign int_len = (wk.interval == 16'h0000) ? 16'h0001 : wk.interval;
  assign tick    = (base_cnt >= base_len - 25'd1);

  // =====================================================================
  // period = interval count times time base
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      base_cnt <= 25'd0;
    else if (tick)
      base_cnt <= 25'd0;
    else
      base_cnt <= base_cnt + 25'd1;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      int_cnt <= 16'h0000;
      wk.wake <= 1'b0;
    end
    else
    begin
      wk.wake <= 1'b0;
      if (tick)
      begin
        if (int_cnt >= int_len - 16'h0001)
        begin
          int_cnt <= 16'h0000;
          wk.wake <= 1'b1;
        end
        else
          int_cnt <= int_cnt + 16'h0001;
      end
    end
  end

  a_wake_on_tick: assert property (@(posedge clk_in) disable iff (reset_in)
    wk.wake |-> $past(tick) && !$past(wk.wake))
    else $error("wake pulse without base tick");
  a_base_bound: assert property (@(posedge clk_in) disable iff (reset_in)
    tick |=> base_cnt == 25'd0)
    else $error("time base counter not restarted at tick");
endmodule
`default_nettype wire

// *** hw/rflcr_top.sv ***
// Overview of operation
// - channel field bits 13:8, code 0 is 902.5 MHz, 0.5 MHz steps, 51 codes
// - power field bits 4:0, code 0 is -15.5 dBm, 1.7 dBm steps
// - each of six sensor pages holds its own channel and power register
// - sensor option bit 11 requests continuous single-channel transmission
// - sensor option bit 6 enables hopping; bit 10 continuous hopping
// - sensor option bit 1 restricts reporting to alarms only
// - wake-up period is interval count times selected time base
// - time base code picks 30.52 us, 0.488 ms, 1/128 s or 1 s
// - each expiry of the wake-up period triggers a sensor update cycle
// - test bit 11 gives gateway continuous carrier, bit 10 hopping
`timescale 1ns/1ps
`default_nettype none
module rflcr_top #(
  parameter logic [24:0] BASE1_CYCLES = 25'(rflcr_pkg::BASE1_CYC),
  parameter logic [24:0] BASE2_CYCLES = 25'(rflcr_pkg::BASE2_CYC),
  parameter logic [24:0] BASE3_CYCLES = 25'(rflcr_pkg::BASE3_CYC)
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       spi_sclk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       spi_din_in,
  output logic            spi_dout_out,
  output logic [5:0]      gateway_channel_out,
  output logic [4:0]      gateway_power_out,
  output logic            gateway_cw_out,
  output logic            gateway_hop_cont_out,
  output logic [5:0]      sensor_cw_out,
  output logic [5:0]      sensor_hop_cont_out,
  output logic [5:0]      sensor_hop_en_out,
  output logic [5:0]      sensor_alarm_only_out,
  output logic [5:0]      sensor_wake_out
);
  logic [2:0]  sclk_s;
  logic [2:0]  cs_n_s;
  logic [1:0]  din_s;
  logic [15:0] rx_shift;
  logic [4:0]  bit_cnt;
  logic [15:0] tx_shift;
  logic [6:0]  rd_addr;
  logic [2:0]  page;
  logic [15:0] gw_cp;
  logic [15:0] gw_test;
  logic [15:0] s_cp   [0:5];
  logic [15:0] s_opt  [0:5];
  logic [15:0] s_int  [0:5];
  logic [15:0] s_base [0:5];
  logic [15:0] rd_data;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        frame_start;
  logic        frame_end;
  logic        wr_en;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_byte;

  // merge one written byte into a register word at the odd/even lane
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [7:0] b,
                                        input logic hi);
    merge = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  // register hit: word address match in either byte lane; the page is not checked
  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = ({a[6:1], 1'b0} == r);
  endfunction

  // =====================================================================
  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sclk_s <= 3'h7;
      cs_n_s <= 3'h7;
      din_s  <= 2'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], spi_sclk_in};
      cs_n_s <= {cs_n_s[1:0], spi_cs_n_in};
      din_s  <= {din_s[0], spi_din_in};
    end
  end

  assign sclk_rise   = sclk_s[1] & ~sclk_s[2] & ~cs_n_s[1];
  assign sclk_fall   = ~sclk_s[1] & sclk_s[2] & ~cs_n_s[1];
  assign frame_start = cs_n_s[2] & ~cs_n_s[1];
  assign frame_end   = ~cs_n_s[2] & cs_n_s[1];
  // short frames are dropped whole, so a glitch on select writes nothing
  assign wr_en   = frame_end & (bit_cnt == rflcr_pkg::FRAME_BITS)
                   & rx_shift[15];
  assign wr_addr = rx_shift[14:8];
  assign wr_byte = rx_shift[7:0];

  // =====================================================================
  // frame receive: write frames store a byte, read frames set the address
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rx_shift <= 16'h0000;
      bit_cnt  <= 5'h00;
      rd_addr  <= 7'h00;
    end
    else
    begin
      if (frame_start)
        bit_cnt <= 5'h00;
      else if (sclk_rise && bit_cnt != rflcr_pkg::FRAME_BITS)
      begin
        rx_shift <= {rx_shift[14:0], din_s[1]};
        bit_cnt  <= bit_cnt + 5'h01;
      end
      if (frame_end && bit_cnt == rflcr_pkg::FRAME_BITS && !rx_shift[15])
        rd_addr <= rx_shift[14:8];
    end
  end

  // =====================================================================
  // transmit: the word addressed by the previous read frame
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      tx_shift     <= 16'h0000;
      spi_dout_out <= 1'b0;
    end
    else if (frame_start)
    begin
      tx_shift     <= {rd_data[14:0], 1'b0};
      spi_dout_out <= rd_data[15];
    end
    else if (sclk_fall)
    begin
      tx_shift     <= {tx_shift[14:0], 1'b0};
      spi_dout_out <= tx_shift[15];
    end
  end

  // =====================================================================
  // register file
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      page    <= rflcr_pkg::RST_PAGE;
      gw_cp   <= rflcr_pkg::RST_CP;
      gw_test <= rflcr_pkg::RST_TEST;
      for (int i = 0; i < rflcr_pkg::NUM_SENS; i++)
      begin
        s_cp[i]   <= rflcr_pkg::RST_CP;
        s_opt[i]  <= rflcr_pkg::RST_OPT;
        s_int[i]  <= rflcr_pkg::RST_INT;
        s_base[i] <= rflcr_pkg::RST_BASE;
      end
    end
    else if (wr_en)
    begin
      if (hit(wr_addr, rflcr_pkg::ADDR_PAGE) && !wr_addr[0]
          && wr_byte <= {5'h00, rflcr_pkg::PAGE_MAX})
        page <= wr_byte[2:0];
      else if (page == 3'h0)
      begin
        if (hit(wr_addr, rflcr_pkg::ADDR_GW_CP))
          gw_cp <= merge(gw_cp, wr_byte, wr_addr[0]);
        if (hit(wr_addr, rflcr_pkg::ADDR_GW_TEST))
          gw_test <= merge(gw_test, wr_byte, wr_addr[0]);
      end
      else
      begin
        if (hit(wr_addr, rflcr_pkg::ADDR_S_CP))
          s_cp[page - 3'h1] <= merge(s_cp[page - 3'h1], wr_byte,
                                     wr_addr[0]);
        if (hit(wr_addr, rflcr_pkg::ADDR_S_OPT))
          s_opt[page - 3'h1] <= merge(s_opt[page - 3'h1], wr_byte,
                                      wr_addr[0]);
        if (hit(wr_addr, rflcr_pkg::ADDR_S_INT))
          s_int[page - 3'h1] <= merge(s_int[page - 3'h1], wr_byte,
                                      wr_addr[0]);
        if (hit(wr_addr, rflcr_pkg::ADDR_S_BASE))
          s_base[page - 3'h1] <= merge(s_base[page - 3'h1], wr_byte,
                                       wr_addr[0]);
      end
    end
  end

  // =====================================================================
  // read mux; unused bits and unmapped addresses read as zero
  always_comb
  begin
    rd_data = 16'h0000;
    if (hit(rd_addr, rflcr_pkg::ADDR_PAGE))
      rd_data = {13'h0000, page};
    else if (page == 3'h0)
    begin
      if (hit(rd_addr, rflcr_pkg::ADDR_GW_CP))
        rd_data = gw_cp & rflcr_pkg::MASK_CP;
      else if (hit(rd_addr, rflcr_pkg::ADDR_GW_TEST))
        rd_data = gw_test & rflcr_pkg::MASK_TEST;
    end
    else
    begin
      if (hit(rd_addr, rflcr_pkg::ADDR_S_CP))
        rd_data = s_cp[page - 3'h1] & rflcr_pkg::MASK_CP;
      else if (hit(rd_addr, rflcr_pkg::ADDR_S_OPT))
        rd_data = s_opt[page - 3'h1] & rflcr_pkg::MASK_OPT;
      else if (hit(rd_addr, rflcr_pkg::ADDR_S_INT))
        rd_data = s_int[page - 3'h1];
      else if (hit(rd_addr, rflcr_pkg::ADDR_S_BASE))
        rd_data = s_base[page - 3'h1] & rflcr_pkg::MASK_BASE;
    end
  end

  // =====================================================================
  // control outputs, taken straight from register bits; wake outputs from the timers
  assign gateway_channel_out  =
    gw_cp[rflcr_pkg::CH_LSB +: rflcr_pkg::CH_W];
  assign gateway_power_out    = gw_cp[rflcr_pkg::PWR_W-1:0];
  assign gateway_cw_out       = gw_test[rflcr_pkg::BIT_CW];
  assign gateway_hop_cont_out = gw_test[rflcr_pkg::BIT_HOPC];

  rflcr_wake_if wk [0:5] ();

  generate
    for (genvar g = 0; g < rflcr_pkg::NUM_SENS; g++)
    begin : g_sens
      assign sensor_cw_out[g]         = s_opt[g][rflcr_pkg::BIT_CW];
      assign sensor_hop_cont_out[g]   = s_opt[g][rflcr_pkg::BIT_HOPC];
      assign sensor_hop_en_out[g]     = s_opt[g][rflcr_pkg::BIT_HOPEN];
      assign sensor_alarm_only_out[g] = s_opt[g][rflcr_pkg::BIT_ALARM];
      assign wk[g].interval           = s_int[g];
      assign wk[g].scale              = s_base[g][1:0];
      assign sensor_wake_out[g]       = wk[g].wake;
      rflcr_wake_timer #(
        .BASE0 (25'(rflcr_pkg::BASE0_CYC)),
        .BASE1 (BASE1_CYCLES),
        .BASE2 (BASE2_CYCLES),
        .BASE3 (BASE3_CYCLES)
      ) u_timer (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .wk       (wk[g])
      );
    end
  endgenerate

  // =====================================================================
  // checks
  sequence s_full_write;
    wr_en && page == 3'h0;
  endsequence

  a_gw_channel_wr: assert property (@(posedge clk_in) disable iff (reset_in)
    s_full_write ##0 (hit(wr_addr, rflcr_pkg::ADDR_GW_CP) && wr_addr[0])
    |=> gateway_channel_out == $past(wr_byte[5:0]))
    else $error("gateway channel not updated by write");
  a_gw_power_wr: assert property (@(posedge clk_in) disable iff (reset_in)
    s_full_write ##0 (hit(wr_addr, rflcr_pkg::ADDR_GW_CP) && !wr_addr[0])
    |=> gateway_power_out == $past(wr_byte[4:0]))
    else $error("gateway power not updated by write");
  a_gw_test_wr: assert property (@(posedge clk_in) disable iff (reset_in)
    s_full_write ##0 (hit(wr_addr, rflcr_pkg::ADDR_GW_TEST) && wr_addr[0])
    |=> gateway_cw_out == $past(wr_byte[3])
        && gateway_hop_cont_out == $past(wr_byte[2]))
    else $error("gateway test bits not updated by write");
  a_sens_cp_wr: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_en && page != 3'h0 && hit(wr_addr, rflcr_pkg::ADDR_S_CP)
    && !wr_addr[0] |=> s_cp[$past(page) - 3'h1][7:0] == $past(wr_byte))
    else $error("sensor channel power write lost");
  a_sens_opt_out: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_en && page == 3'h1 && hit(wr_addr, rflcr_pkg::ADDR_S_OPT)
    && wr_addr[0] |=> sensor_cw_out[0] == $past(wr_byte[3])
    && sensor_hop_cont_out[0] == $past(wr_byte[2]))
    else $error("sensor continuous mode bits wrong");
  a_sens_hop_out: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_en && page == 3'h1 && hit(wr_addr, rflcr_pkg::ADDR_S_OPT)
    && !wr_addr[0] |=> sensor_hop_en_out[0] == $past(wr_byte[6])
    && sensor_alarm_only_out[0] == $past(wr_byte[1]))
    else $error("sensor hop or alarm bit wrong");
  a_gw_wr_isolated: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_en && page != 3'h0 |=> $stable(gw_cp) && $stable(gw_test))
    else $error("sensor page write touched gateway");
  a_dout_first_bit: assert property (@(posedge clk_in) disable iff (reset_in)
    frame_start |=> spi_dout_out == $past(rd_data[15]))
    else $error("read data msb not presented at frame start");
endmodule
`default_nettype wire

// *** hw/rflcr_dummy_unused.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** test/rflcr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// host side of the serial port: mode 3, msb first, 16-bit frames
module rflcr_host_model (
  input  wire logic        clk_in,
  input  wire logic        dout_in,
  output logic             sclk_out,
  output logic             cs_n_out,
  output logic             din_out,
  output logic [15:0]      rx_word_out,
  output logic             rx_stb_out
);
  initial
  begin
    sclk_out    = 1'b1;
    cs_n_out    = 1'b1;
    din_out     = 1'b0;
    rx_word_out = 16'h0000;
    rx_stb_out  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // half periods of 5 clocks stay clear of the 4-clock minimum
  task automatic frame(input logic [15:0] tx, input int nbits, input bit cap);
    logic [15:0] rx;
    rx = 16'h0000;
    wait_clk(1);
    cs_n_out = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      wait_clk(5);
      // dout stands until the fall, so take it just before
      rx = {rx[14:0], dout_in};
      sclk_out = 1'b0;
      din_out  = tx[15-i];
      wait_clk(5);
      sclk_out = 1'b1;
    end
    wait_clk(5);
    cs_n_out = 1'b1;
    // line has no pull, so a released line shows the inverse
    din_out = ~din_out;
    if (cap)
    begin
      rx_word_out = rx;
      rx_stb_out  = 1'b1;
      wait_clk(1);
      rx_stb_out  = 1'b0;
    end
    wait_clk(5);
  endtask
endmodule
`default_nettype wire

// *** test/rf_link_config_registers_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module rf_link_config_registers_bench;
  localparam int LIMIT = 90000;
  localparam int B0    = int'(rflcr_pkg::BASE0_CYC);
  localparam int B1    = 20;
  localparam int B2    = 30;
  localparam int B3    = 50;
  logic        clk_in   = 1'b0;
  logic        reset_in = 1'b1;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic [15:0] rx_word;
  logic        rx_stb;
  logic [5:0]  gw_ch;
  logic [4:0]  gw_pwr;
  logic        gw_cw;
  logic        gw_hc;
  logic [5:0]  s_cw;
  logic [5:0]  s_hc;
  logic [5:0]  s_he;
  logic [5:0]  s_al;
  logic [5:0]  s_wake;
  int          miscompares = 0;
  int          checked     = 0;
  int          cycles      = 0;
  logic [15:0] exp_q[$];

  always #20 clk_in = ~clk_in;

  // short time bases keep the wake periods within a brief run
  rflcr_top #(
    .BASE1_CYCLES(25'(B1)),
    .BASE2_CYCLES(25'(B2)),
    .BASE3_CYCLES(25'(B3))
  ) dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_din_in(din), .spi_dout_out(dout),
    .gateway_channel_out(gw_ch), .gateway_power_out(gw_pwr),
    .gateway_cw_out(gw_cw), .gateway_hop_cont_out(gw_hc),
    .sensor_cw_out(s_cw), .sensor_hop_cont_out(s_hc),
    .sensor_hop_en_out(s_he), .sensor_alarm_only_out(s_al),
    .sensor_wake_out(s_wake)
  );

  rflcr_host_model host_u (
    .clk_in(clk_in), .dout_in(dout), .sclk_out(sclk), .cs_n_out(cs_n),
    .din_out(din), .rx_word_out(rx_word), .rx_stb_out(rx_stb)
  );

  // =====================================================================
  // checking and verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (rx_stb === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(rx_word, ~rx_word, "read with no note");
      else
        check(rx_word, exp_q.pop_front(), "read data");
    end
    if (cycles == LIMIT)
    begin
      miscompares++;
      $display("wrong value at %0t: run timed out", $time);
      give_verdict();
    end
  end

  // =====================================================================
  // register access over the serial port
  task automatic wr8(input logic [6:0] a, input logic [7:0] d);
    host_u.frame({1'b1, a, d}, 16, 1'b0);
  endtask

  // a word is two byte writes, low byte first
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    wr8(a, d[7:0]);
    wr8(a + 7'h01, d[15:8]);
  endtask

  // read data comes back in the following frame
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    host_u.frame({1'b0, a, 8'h00}, 16, 1'b0);
    exp_q.push_back(exp);
    host_u.frame(16'h0000, 16, 1'b1);
  endtask

  task automatic page(input int p);
    wr8(rflcr_pkg::ADDR_PAGE, 8'(p));
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    #1;
    reset_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  task automatic wait_wake(output int t);
    repeat (12000)
    begin
      @(posedge clk_in);
      #1;
      if (s_wake !== 6'h00)
        break;
    end
    t = cycles;
    check(16'(s_wake), 16'h0001, "wake pulse");
  endtask

  // the first pulse after a change may mix old and new settings
  task automatic spacing(input int exp);
    int ta;
    int tb;
    wait_wake(ta);
    wait_wake(tb);
    check(16'(tb - ta), 16'(exp), "wake spacing");
  endtask

  // =====================================================================
  // main sequence
  initial
  begin
    logic [15:0] v [1:6];
    logic [15:0] tv;
    logic [5:0]  e_cw;
    logic [5:0]  e_hc;
    logic [5:0]  e_he;
    logic [5:0]  e_al;
    void'($urandom(59));
    do_reset();
    // power stays at its reset code, below the level that needs hopping
    page(1);
    wr(rflcr_pkg::ADDR_S_INT, 16'h0064);
    spacing(100 * B1);
    wr8(rflcr_pkg::ADDR_S_BASE, 8'h02);
    spacing(100 * B2);
    wr8(rflcr_pkg::ADDR_S_BASE, 8'h03);
    spacing(100 * B3);
    // slow base first so the short interval is not overtaken
    wr8(rflcr_pkg::ADDR_S_BASE, 8'h00);
    wr8(rflcr_pkg::ADDR_S_INT, 8'h05);
    spacing(5 * B0);
    $display("test wake_period done");

    do_reset();
    check({3'h0, gw_ch, gw_pwr, gw_cw, gw_hc}, 16'h0020, "gw out");
    check({4'h0, s_cw, s_hc}, 16'h0000, "cw hop out");
    check({4'h0, s_he, s_al}, 16'h0000, "en alarm out");
    rd(rflcr_pkg::ADDR_GW_CP, rflcr_pkg::RST_CP);
    rd(rflcr_pkg::ADDR_GW_TEST, rflcr_pkg::RST_TEST);
    for (int p = 1; p <= 6; p++)
    begin
      page(p);
      rd(rflcr_pkg::ADDR_S_CP, rflcr_pkg::RST_CP);
      rd(rflcr_pkg::ADDR_S_OPT, rflcr_pkg::RST_OPT);
      rd(rflcr_pkg::ADDR_S_INT, rflcr_pkg::RST_INT);
      rd(rflcr_pkg::ADDR_S_BASE, rflcr_pkg::RST_BASE);
    end
    $display("test reset_values done");

    for (int p = 1; p <= 6; p++)
    begin
      v[p] = {2'b00, 6'($urandom_range(50)), 3'b000,
              5'($urandom_range(15))};
      page(p);
      // hopping goes on first: the random power may need it
      wr8(rflcr_pkg::ADDR_S_OPT, 8'h40);
      wr(rflcr_pkg::ADDR_S_CP, v[p]);
    end
    for (int p = 1; p <= 6; p++)
    begin
      page(p);
      rd(rflcr_pkg::ADDR_S_CP, v[p]);
    end
    page(0);
    wr(rflcr_pkg::ADDR_GW_CP, 16'h320f);
    check(16'({gw_ch, gw_pwr}), 16'({6'd50, 5'd15}), "gw fields");
    rd(rflcr_pkg::ADDR_GW_CP, 16'h320f);
    $display("test channel_power done");

    for (int p = 1; p <= 6; p++)
    begin
      tv = 16'($urandom) & rflcr_pkg::MASK_OPT;
      page(p);
      // power back to its reset code before hopping is dropped
      if (!tv[6])
        wr8(rflcr_pkg::ADDR_S_CP, 8'h08);
      wr(rflcr_pkg::ADDR_S_OPT, tv);
      e_cw[p-1] = tv[11];
      e_hc[p-1] = tv[10];
      e_he[p-1] = tv[6];
      e_al[p-1] = tv[1];
      rd(rflcr_pkg::ADDR_S_OPT, tv);
    end
    check({4'h0, s_cw, s_hc}, {4'h0, e_cw, e_hc}, "cw hop out");
    check({4'h0, s_he, s_al}, {4'h0, e_he, e_al}, "en alarm out");
    page(0);
    for (int k = 0; k < 4; k++)
    begin
      tv = 16'(k) << 10;
      wr(rflcr_pkg::ADDR_GW_TEST, tv);
      check({14'h0, gw_cw, gw_hc}, 16'(k), "gw test out");
      rd(rflcr_pkg::ADDR_GW_TEST, tv);
    end
    $display("test radio_modes done");

    rd(7'h30, 16'h0000);
    wr8(rflcr_pkg::ADDR_PAGE, 8'h07);
    wr8(rflcr_pkg::ADDR_PAGE, 8'h09);
    rd(rflcr_pkg::ADDR_PAGE, 16'h0000);
    // lead frame leaves a write header that a taken short frame would use
    host_u.frame(16'h0088, 16, 1'b0);
    host_u.frame(16'h8800, 8, 1'b0);
    rd(rflcr_pkg::ADDR_GW_CP, 16'h320f);
    check(16'(exp_q.size()), 16'h0000, "reads left over");
    $display("test refusals done");
    give_verdict();
  end
endmodule
`default_nettype wire
